//--- design/cds_pkg.sv
// Purpose: Shared constants and types for the channel display scanner.
// Assumes: One 250 MHz system clock, AXI4-Lite register access.
// Notes:   Offsets are byte addresses of 32-bit aligned words.
package cds_pkg;

  // ---------------------------------------------------------------
  // Register map and field layout
  // ---------------------------------------------------------------
  localparam logic [7:0] CDS_REG_CONFIG = 8'h00;
  localparam logic [7:0] CDS_REG_DWELL = 8'h04;
  localparam logic [7:0] CDS_REG_MAP_LO = 8'h08;
  localparam logic [7:0] CDS_REG_MAP_HI = 8'h0c;
  localparam logic [7:0] CDS_REG_STATUS = 8'h10;
  localparam int CDS_CFG_NI_LSB = 0;
  localparam int CDS_CFG_NC_LSB = 4;
  localparam int CDS_CFG_NA_LSB = 8;
  localparam int CDS_CFG_SHOW_BIT = 12;
  localparam int CDS_CFG_TAG_BIT = 13;
  localparam int CDS_ST_MODE_LSB = 5;
  localparam int CDS_ST_OPT_BIT = 7;
  localparam int CDS_ST_SIX_BIT = 8;

  // ---------------------------------------------------------------
  // Reset values and ranges
  // ---------------------------------------------------------------
  localparam logic [3:0] CDS_NI_DEF = 4'h8;
  localparam logic [3:0] CDS_NC_DEF = 4'h5;
  localparam logic [3:0] CDS_NA_DEF = 4'h2;
  localparam logic [3:0] CDS_CNT_MIN_NI = 4'h1;
  localparam logic [3:0] CDS_CNT_MAX = 4'h8;
  localparam logic [7:0] CDS_DWELL_DEF = 8'h05;
  localparam logic [7:0] CDS_DWELL_MAX = 8'hc8;
  localparam logic CDS_SHOW_DEF = 1'b1;
  localparam logic CDS_TAG_DEF = 1'b1;
  localparam logic [7:0] CDS_RELAY_STD_MASK = 8'h0f;
  localparam logic [7:0] CDS_RELAY_ALL_MASK = 8'hff;
  localparam logic [1:0] CDS_RESP_OKAY = 2'b00;
  localparam logic [1:0] CDS_RESP_SLVERR = 2'b10;

  // ---------------------------------------------------------------
  // Timing, in seconds and in clock cycles
  // ---------------------------------------------------------------
  localparam int CDS_CLK_NS = 4;
  localparam int CDS_SEC_NS = 1_000_000_000;
  localparam int CDS_SEC_CYCLES = CDS_SEC_NS / CDS_CLK_NS;
  localparam logic [11:0] CDS_MANUAL_HOLD_S = 12'd20;
  localparam logic [11:0] CDS_LONG_HOLD_S = 12'd3600;
  localparam logic [1:0] CDS_PRESS_LONG_S = 2'd3;

  // Display mode; Gray coded along scan, manual, long hold.
  typedef enum logic [1:0] {
    CDS_SCAN = 2'b00,
    CDS_MANUAL = 2'b01,
    CDS_LONG = 2'b11,
    CDS_STOP = 2'b10
  } cds_mode_type;

endpackage

//--- design/cds_sec_tick.sv
// Purpose: One-second enable pulse derived from the system clock.
// Assumes: TICK_CYCLES is at least 2.
// Notes:   Shorten TICK_CYCLES in simulation to speed up timing.
`timescale 1ns/1ns
module cds_sec_tick
  import cds_pkg::*;
#(
  parameter int TICK_CYCLES = CDS_SEC_CYCLES
)
(
  input wire logic clk_sys,
  input wire logic srst,
  output logic tick_q
);

  localparam int CW = $clog2(TICK_CYCLES);
  localparam logic [CW-1:0] LAST = CW'(TICK_CYCLES - 1);

  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic tick_d;

  // ---------------------------------------------------------------
  // Divider
  // ---------------------------------------------------------------
  // The pulse is registered so that consumers see a clean enable.
  always_comb
  begin
    tick_d = (cnt_q == LAST);
    cnt_d = tick_d ? '0 : cnt_q + CW'(1);
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      cnt_q <= '0;
      tick_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      tick_q <= tick_d;
    end
  end

endmodule // cds_sec_tick

//--- design/cds_scanner.sv
// Purpose: Channel configuration and front-panel display sequencing.
// Assumes: Buttons and straps are asynchronous pins; alarm_active is
//          produced on clk_sys by the alarm logic.
// Notes:   Registers are reached over AXI4-Lite, one word each.
`timescale 1ns/1ns
// Summary of operation
// - Active inputs 1..8, default 8; only inputs up to count shown.
// - Calculated channel count accepted from 0 to 8.
// - Calculated channels are results, not physical inputs; flagged apart.
// - Enabled calculated channels follow the inputs in the display order.
// - Alarm count 0..8, default 2; alarms beyond count are idle.
// - Each alarm may drive any set of fitted relays.
// - Four relays standard, four more when the option is fitted.
// - Dwell time 0..200 whole seconds, default 5.
// - Nonzero dwell shows each channel then steps to the next higher.
// - Zero dwell stops scanning; only up and down buttons change channel.
// - Manual selection while scanning holds about 20 s, then scan resumes.
// - Button held 3 s in manual selection holds the channel one hour.
// - Channel processing continues regardless of display scanning state.
// - Channel tag enable, default on, shown only on six-digit displays.
module cds_scanner
  import cds_pkg::*;
#(
  parameter int TICK_CYCLES = CDS_SEC_CYCLES,
  parameter int ADDR_W = 8
)
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic btn_up,
  input wire logic btn_down,
  input wire logic relay_option_fitted,
  input wire logic six_digit_display,
  input wire logic [7:0] alarm_active,
  output logic [3:0] disp_channel_q,
  output logic disp_is_calc_q,
  output logic tag_show_q,
  output logic scan_running_q,
  output logic [7:0] relay_out_q
);

  // ---------------------------------------------------------------
  // Helper functions
  // ---------------------------------------------------------------
  function automatic logic [31:0] merge(input logic [31:0] old,
    input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (strb[i]) r[i*8 +: 8] = nw[i*8 +: 8];
    return r;
  endfunction

  function automatic logic [3:0] clamp(input logic [3:0] v,
    input logic [3:0] lo);
    return (v < lo) ? lo : ((v > CDS_CNT_MAX) ? CDS_CNT_MAX : v);
  endfunction

  function automatic logic [3:0] step_up(input logic [3:0] ch,
    input logic [4:0] total);
    return (({1'b0, ch} + 5'd1) >= total) ? 4'h0 : ch + 4'h1;
  endfunction

  function automatic logic [3:0] step_dn(input logic [3:0] ch,
    input logic [4:0] total);
    // A channel left beyond a shrunk total also wraps to the last one.
    return (ch == 4'h0 || {1'b0, ch} >= total) ? 4'((total - 5'd1))
                                               : ch - 4'h1;
  endfunction

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic aw_rdy_q, aw_rdy_d, ar_rdy_q, ar_rdy_d;
  logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic [3:0] ni_q, ni_d, nc_q, nc_d, na_q, na_d;
  logic show_q, show_d, tag_q, tag_d;
  logic [7:0] dwell_q, dwell_d;
  logic [7:0] map_q [0:7];
  logic [7:0] map_d [0:7];
  logic [3:0] sync_s1_q, sync_s2_q;
  logic up_prev_q, dn_prev_q;
  cds_mode_type mode_q, mode_d;
  logic [3:0] ch_q, ch_d;
  logic [7:0] dwell_cnt_q, dwell_cnt_d;
  logic [11:0] hold_cnt_q, hold_cnt_d;
  logic [1:0] press_cnt_q, press_cnt_d;
  logic [3:0] disp_channel_d;
  logic disp_is_calc_d, tag_show_d, scan_running_d;
  logic [7:0] relay_out_d, fitted;
  logic [7:0] alarm_en;
  logic [4:0] total;
  logic tick, up_edge, dn_edge, btn_held;
  logic [31:0] cfg_word, st_word, wr_word;
  logic [ADDR_W-1:0] waddr_al, raddr_al;

  cds_sec_tick #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_tick (
    .clk_sys(clk_sys),
    .srst(srst),
    .tick_q(tick)
  );

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  // Bit 0 up, 1 down, 2 relay option, 3 six-digit strap.
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      sync_s1_q <= '0;
      sync_s2_q <= '0;
    end
    else
    begin
      sync_s1_q <= {six_digit_display, relay_option_fitted,
                    btn_down, btn_up};
      sync_s2_q <= sync_s1_q;
    end
  end

  assign up_edge = sync_s2_q[0] & ~up_prev_q;
  assign dn_edge = sync_s2_q[1] & ~dn_prev_q;
  assign btn_held = sync_s2_q[0] | sync_s2_q[1];
  assign fitted = sync_s2_q[2] ? CDS_RELAY_ALL_MASK
                               : CDS_RELAY_STD_MASK;
  assign total = {1'b0, ni_q} + (show_q ? {1'b0, nc_q} : 5'd0);

  // Alarms at or beyond the configured count are held idle.
  genvar ga;
  generate
    for (ga = 0; ga < 8; ga++)
    begin : g_alarm
      assign alarm_en[ga] = (4'(ga) < na_q);
    end
  endgenerate

  // ---------------------------------------------------------------
  // AXI4-Lite slave and register file
  // ---------------------------------------------------------------
  assign waddr_al = {s_axi_awaddr[ADDR_W-1:2], 2'b00};
  assign raddr_al = {s_axi_araddr[ADDR_W-1:2], 2'b00};
  assign cfg_word = {18'h0, tag_q, show_q, na_q, nc_q, ni_q};
  assign st_word = {23'h0, sync_s2_q[3], sync_s2_q[2], mode_q,
                    disp_is_calc_q, ch_q};

  // Address and data are taken together in one cycle; the bus allows
  // a slave to wait for both, which keeps the decode single-path.
  always_comb
  begin
    aw_rdy_d = ~aw_rdy_q & ~bvalid_q & s_axi_awvalid & s_axi_wvalid;
    ar_rdy_d = ~ar_rdy_q & ~rvalid_q & s_axi_arvalid;
    bvalid_d = aw_rdy_q | (bvalid_q & ~s_axi_bready);
    rvalid_d = ar_rdy_q | (rvalid_q & ~s_axi_rready);
    wr_word = merge(cfg_word, s_axi_wdata, s_axi_wstrb);
    bresp_d = bresp_q;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    ni_d = ni_q;
    nc_d = nc_q;
    na_d = na_q;
    show_d = show_q;
    tag_d = tag_q;
    dwell_d = dwell_q;
    map_d = map_q;
    if (aw_rdy_q)
    begin
      bresp_d = CDS_RESP_OKAY;
      if (waddr_al == ADDR_W'(CDS_REG_CONFIG))
      begin
        ni_d = clamp(wr_word[CDS_CFG_NI_LSB +: 4],
                     CDS_CNT_MIN_NI);
        nc_d = clamp(wr_word[CDS_CFG_NC_LSB +: 4], 4'h0);
        na_d = clamp(wr_word[CDS_CFG_NA_LSB +: 4], 4'h0);
        show_d = wr_word[CDS_CFG_SHOW_BIT];
        tag_d = wr_word[CDS_CFG_TAG_BIT];
      end
      else if (waddr_al == ADDR_W'(CDS_REG_DWELL))
      begin
        if (s_axi_wstrb[0])
          dwell_d = (s_axi_wdata[7:0] > CDS_DWELL_MAX) ? CDS_DWELL_MAX
                                                    : s_axi_wdata[7:0];
      end
      else if (waddr_al == ADDR_W'(CDS_REG_MAP_LO) ||
               waddr_al == ADDR_W'(CDS_REG_MAP_HI))
      begin
        for (int b = 0; b < 4; b++)
          if (s_axi_wstrb[b])
            map_d[b + (waddr_al[2] ? 4 : 0)] =
              s_axi_wdata[b*8 +: 8] & fitted;
      end
      else if (waddr_al != ADDR_W'(CDS_REG_STATUS))
        bresp_d = CDS_RESP_SLVERR;
    end
    if (ar_rdy_q)
    begin
      rresp_d = CDS_RESP_OKAY;
      if (raddr_al == ADDR_W'(CDS_REG_CONFIG))
        rdata_d = cfg_word;
      else if (raddr_al == ADDR_W'(CDS_REG_DWELL))
        rdata_d = {24'h0, dwell_q};
      else if (raddr_al == ADDR_W'(CDS_REG_MAP_LO))
        rdata_d = {map_q[3], map_q[2], map_q[1], map_q[0]};
      else if (raddr_al == ADDR_W'(CDS_REG_MAP_HI))
        rdata_d = {map_q[7], map_q[6], map_q[5], map_q[4]};
      else if (raddr_al == ADDR_W'(CDS_REG_STATUS))
        rdata_d = st_word;
      else
      begin
        rdata_d = 32'h0;
        rresp_d = CDS_RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      aw_rdy_q <= 1'b0;
      ar_rdy_q <= 1'b0;
      bvalid_q <= 1'b0;
      rvalid_q <= 1'b0;
      bresp_q <= CDS_RESP_OKAY;
      rresp_q <= CDS_RESP_OKAY;
      rdata_q <= 32'h0;
      ni_q <= CDS_NI_DEF;
      nc_q <= CDS_NC_DEF;
      na_q <= CDS_NA_DEF;
      show_q <= CDS_SHOW_DEF;
      tag_q <= CDS_TAG_DEF;
      dwell_q <= CDS_DWELL_DEF;
      for (int i = 0; i < 8; i++)
        map_q[i] <= 8'h00;
    end
    else
    begin
      aw_rdy_q <= aw_rdy_d;
      ar_rdy_q <= ar_rdy_d;
      bvalid_q <= bvalid_d;
      rvalid_q <= rvalid_d;
      bresp_q <= bresp_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
      ni_q <= ni_d;
      nc_q <= nc_d;
      na_q <= na_d;
      show_q <= show_d;
      tag_q <= tag_d;
      dwell_q <= dwell_d;
      map_q <= map_d;
    end
  end

  assign s_axi_awready = aw_rdy_q;
  assign s_axi_wready = aw_rdy_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = ar_rdy_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;

  // ---------------------------------------------------------------
  // Display sequencer
  // ---------------------------------------------------------------
  // A press always steps the channel; the mode then decides how long
  // the choice stands. Hold timing is in whole seconds of the shared
  // tick, so the 20 s hold is accurate to within one second.
  always_comb
  begin
    mode_d = mode_q;
    ch_d = ch_q;
    dwell_cnt_d = dwell_cnt_q;
    hold_cnt_d = hold_cnt_q;
    press_cnt_d = press_cnt_q;
    if ({1'b0, ch_q} >= total)
      ch_d = 4'h0;
    case (mode_q)
      CDS_SCAN:
      begin
        if (tick)
        begin
          if (dwell_cnt_q + 8'd1 >= dwell_q)
          begin
            dwell_cnt_d = 8'h00;
            ch_d = step_up(ch_q, total);
          end
          else
            dwell_cnt_d = dwell_cnt_q + 8'd1;
        end
      end
      CDS_MANUAL:
      begin
        if (tick)
        begin
          hold_cnt_d = hold_cnt_q + 12'd1;
          if (btn_held)
            press_cnt_d = press_cnt_q + 2'd1;
          if (btn_held && press_cnt_q + 2'd1 == CDS_PRESS_LONG_S)
          begin
            mode_d = CDS_LONG;
            hold_cnt_d = 12'h000;
          end
          else if (hold_cnt_q + 12'd1 >= CDS_MANUAL_HOLD_S)
            mode_d = CDS_SCAN;
        end
      end
      CDS_LONG:
      begin
        if (tick)
        begin
          hold_cnt_d = hold_cnt_q + 12'd1;
          if (hold_cnt_q + 12'd1 >= CDS_LONG_HOLD_S)
            mode_d = CDS_SCAN;
        end
      end
      default:
        mode_d = CDS_STOP;
    endcase
    if (up_edge | dn_edge)
    begin
      ch_d = up_edge ? step_up(ch_q, total) : step_dn(ch_q, total);
      hold_cnt_d = 12'h000;
      press_cnt_d = 2'd0;
      dwell_cnt_d = 8'h00;
      if (dwell_q != 8'h00)
        mode_d = CDS_MANUAL;
    end
    else if (dwell_q == 8'h00)
      mode_d = CDS_STOP;
    else if (mode_q == CDS_STOP)
    begin
      mode_d = CDS_SCAN;
      dwell_cnt_d = 8'h00;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      mode_q <= CDS_SCAN;
      ch_q <= 4'h0;
      dwell_cnt_q <= 8'h00;
      hold_cnt_q <= 12'h000;
      press_cnt_q <= 2'd0;
      up_prev_q <= 1'b0;
      dn_prev_q <= 1'b0;
    end
    else
    begin
      mode_q <= mode_d;
      ch_q <= ch_d;
      dwell_cnt_q <= dwell_cnt_d;
      hold_cnt_q <= hold_cnt_d;
      press_cnt_q <= press_cnt_d;
      up_prev_q <= sync_s2_q[0];
      dn_prev_q <= sync_s2_q[1];
    end
  end

  // ---------------------------------------------------------------
  // Output stage
  // ---------------------------------------------------------------
  // Relays follow alarms in every mode, so a stopped display never
  // holds back alarm handling.
  always_comb
  begin
    disp_is_calc_d = (ch_d >= ni_q);
    disp_channel_d = disp_is_calc_d ? ch_d - ni_q + 4'h1
                                    : ch_d + 4'h1;
    tag_show_d = tag_q & sync_s2_q[3];
    scan_running_d = (mode_d == CDS_SCAN);
    relay_out_d = 8'h00;
    for (int a = 0; a < 8; a++)
      if (alarm_en[a] & alarm_active[a])
        relay_out_d = relay_out_d | (map_q[a] & fitted);
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      disp_channel_q <= 4'h1;
      disp_is_calc_q <= 1'b0;
      tag_show_q <= 1'b0;
      scan_running_q <= 1'b0;
      relay_out_q <= 8'h00;
    end
    else
    begin
      disp_channel_q <= disp_channel_d;
      disp_is_calc_q <= disp_is_calc_d;
      tag_show_q <= tag_show_d;
      scan_running_q <= scan_running_d;
      relay_out_q <= relay_out_d;
    end
  end

endmodule // cds_scanner

//--- design/cds_scanner_unused.sv
// Purpose: Reserved file; it holds no logic.
// Assumes: Nothing.
// Notes:   Nothing here is compiled into the block.

//--- verification/cds_scanner_chk.sv
// Purpose: Port-level assertions for the channel display scanner.
// Assumes: One clk_sys domain with synchronous active-high srst.
// Notes:   Bound to every cds_scanner instance below.
`timescale 1ns/1ns
module cds_scanner_chk
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [7:0] alarm_active,
  input wire logic [3:0] disp_channel_q,
  input wire logic tag_show_q,
  input wire logic scan_running_q,
  input wire logic [7:0] relay_out_q
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  // Reset must clear the display and relays whatever came before.
  reset_state_a: assert property (disable iff (1'b0)
    srst |=> disp_channel_q == 4'h1 && relay_out_q == 8'h00 &&
    !scan_running_q && !tag_show_q)
    else $error("outputs not cleared by reset");
  release_run_a: assert property ($fell(srst) |=> scan_running_q)
    else $error("scan not started after reset");
  chan_range_a: assert property (
    disp_channel_q >= 4'h1 && disp_channel_q <= 4'h8)
    else $error("displayed channel out of range");
  relay_quiet_a: assert property (
    alarm_active == 8'h00 |=> relay_out_q == 8'h00)
    else $error("relay driven with no alarm");

  // Bus handshake shape; one flop serves both write readies.
  aw_w_pair_a: assert property (s_axi_awready == s_axi_wready)
    else $error("write readies differ");
  wr_resp_a: assert property (
    s_axi_awready |=> !s_axi_awready && s_axi_bvalid)
    else $error("write response late");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  rd_resp_a: assert property (
    s_axi_arready |=> !s_axi_arready && s_axi_rvalid)
    else $error("read response late");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  b_done_a: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  r_done_a: assert property (
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read response repeated");

  // Main scenarios reached.
  scan_step_c: cover property (scan_running_q && $changed(disp_channel_q));
  manual_c: cover property ($fell(scan_running_q));
  slverr_c: cover property (s_axi_bvalid && s_axi_bresp == 2'b10);
endmodule // cds_scanner_chk

bind cds_scanner cds_scanner_chk chk_u (.*);

//--- verification/cds_panel_model.sv
// Purpose: Front-panel push-button model for the display scanner.
// Assumes: Buttons are plain levels, high while pressed.
// Notes:   Rests low long enough for the input synchroniser.
`timescale 1ns/1ns
module cds_panel_model
(
  input wire logic clk_sys,
  output logic btn_up,
  output logic btn_down
);
  // Both buttons released at start.
  initial
  begin
    btn_up = 1'b0;
    btn_down = 1'b0;
  end

  // Press one button for hold cycles, then release and rest.
  task automatic press(input logic up, input int hold);
    @(posedge clk_sys);
    if (up)
      btn_up <= 1'b1;
    else
      btn_down <= 1'b1;
    repeat (hold) @(posedge clk_sys);
    btn_up <= 1'b0;
    btn_down <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask
endmodule // cds_panel_model

//--- verification/testbench.sv
// Purpose: Self-checking bench for the channel display scanner.
// Assumes: One-second tick shortened to T cycles.
// Notes:   AXI4-Lite master tasks plus a front-panel model.
`timescale 1ns/1ns
module testbench;
  import cds_pkg::*;
  localparam int T = 10;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic relay_option_fitted = 1'b0, six_digit_display = 1'b0;
  logic [7:0] alarm_active = 8'h00;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic btn_up, btn_down, disp_is_calc_q, tag_show_q, scan_running_q;
  logic [3:0] disp_channel_q, held;
  logic [7:0] relay_out_q;
  int failures = 0, samples_checked = 0, cyc = 0, last = 0, gap = 0;
  int i, t0;

  always #2 clk_sys = ~clk_sys;

  cds_scanner #(.TICK_CYCLES(T)) dut_u (.*);
  cds_panel_model panel_u (.*);

  // Compare one value and count it.
  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      $display("unexpected %s expected %h seen %h", nm, e, g);
      failures++;
    end
  endtask

  // Write one word; bready stands from the data handshake to bvalid.
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
    input logic [1:0] er);
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do @(posedge clk_sys); while (s_axi_awready !== 1'b1);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    s_axi_bready <= 1'b1;
    do @(posedge clk_sys); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk("bresp", 32'(er), 32'(s_axi_bresp));
  endtask

  // Read one word and compare data and response.
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
    input logic [1:0] er);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge clk_sys); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do @(posedge clk_sys); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk("rdata", e, s_axi_rdata);
    chk("rresp", 32'(er), 32'(s_axi_rresp));
  endtask

  // Wait for the shown channel to change; gap is cycles since last.
  task automatic nxt();
    logic [4:0] o;
    o = {disp_channel_q, disp_is_calc_q};
    do @(posedge clk_sys); while ({disp_channel_q, disp_is_calc_q} === o);
    gap = cyc - last;
    last = cyc;
  endtask

  // Expect the next shown channel and, if g is nonzero, its spacing.
  task automatic step(input logic [3:0] ch, input logic c, input int g);
    nxt();
    chk("chan", 32'(ch), 32'(disp_channel_q));
    chk("calc", 32'(c), 32'(disp_is_calc_q));
    if (g != 0)
      chk("gap", 32'(g), 32'(gap));
  endtask

  // Print the verdict and stop.
  task automatic conclude();
    if (failures == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Cycle count and hang guard; the run needs about 37000 cycles.
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      failures++;
      conclude();
    end
  end

  // Main sequence.
  initial
  begin
    repeat (5) @(posedge clk_sys);
    srst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk("run", 1, 32'(scan_running_q));
    chk("chan", 1, 32'(disp_channel_q));
    rd(CDS_REG_CONFIG, 32'h3258, CDS_RESP_OKAY);
    rd(CDS_REG_DWELL, 32'h5, CDS_RESP_OKAY);
    rd(CDS_REG_MAP_LO, 32'h0, CDS_RESP_OKAY);
    rd(8'h14, 32'h0, CDS_RESP_SLVERR);
    wr(8'h20, 32'h1, CDS_RESP_SLVERR);
    wr(CDS_REG_STATUS, 32'hffff, CDS_RESP_OKAY);
    wr(CDS_REG_CONFIG, 32'h3290, CDS_RESP_OKAY);
    rd(CDS_REG_CONFIG, 32'h3281, CDS_RESP_OKAY);
    wr(CDS_REG_CONFIG, 32'h390f, CDS_RESP_OKAY);
    rd(CDS_REG_CONFIG, 32'h3808, CDS_RESP_OKAY);
    wr(CDS_REG_DWELL, 32'hff, CDS_RESP_OKAY);
    rd(CDS_REG_DWELL, 32'hc8, CDS_RESP_OKAY);
    s_axi_wstrb <= 4'h1;
    wr(CDS_REG_CONFIG, 32'hff02, CDS_RESP_OKAY);
    rd(CDS_REG_CONFIG, 32'h3802, CDS_RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    // Two inputs, one calculated channel shown, two-second dwell.
    wr(CDS_REG_CONFIG, 32'h3212, CDS_RESP_OKAY);
    wr(CDS_REG_DWELL, 32'h2, CDS_RESP_OKAY);
    i = 0;
    do
    begin
      nxt();
      i++;
    end
    while (!(disp_channel_q === 4'h1 && disp_is_calc_q === 1'b0) && i < 12);
    step(4'h2, 1'b0, 2 * T);
    step(4'h1, 1'b1, 2 * T);
    step(4'h1, 1'b0, 2 * T);
    wr(CDS_REG_CONFIG, 32'h2212, CDS_RESP_OKAY);
    step(4'h2, 1'b0, 0);
    step(4'h1, 1'b0, 2 * T);
    // Short press holds for twenty ticks, long hold for an hour.
    t0 = cyc;
    panel_u.press(1'b1, 3);
    chk("chan", 2, 32'(disp_channel_q));
    chk("run", 0, 32'(scan_running_q));
    do @(posedge clk_sys); while (scan_running_q !== 1'b1);
    chk("hold", 1, 32'(cyc - t0 >= 18 * T && cyc - t0 <= 21 * T));
    t0 = cyc;
    panel_u.press(1'b0, 4 * T + 5);
    repeat (25 * T) @(posedge clk_sys);
    chk("run", 0, 32'(scan_running_q));
    do @(posedge clk_sys); while (scan_running_q !== 1'b1);
    chk("long", 1, 32'(cyc - t0 >= 3595 * T && cyc - t0 <= 3610 * T));
    // Zero dwell stops the scan; buttons still step.
    wr(CDS_REG_DWELL, 32'h0, CDS_RESP_OKAY);
    repeat (2) @(posedge clk_sys);
    chk("run", 0, 32'(scan_running_q));
    held = disp_channel_q;
    repeat (5 * T) @(posedge clk_sys);
    chk("stop", 32'(held), 32'(disp_channel_q));
    panel_u.press(1'b0, 3);
    chk("chan", held == 4'h1 ? 32'h2 : 32'h1, 32'(disp_channel_q));
    // Relay maps, with and without the relay option.
    wr(CDS_REG_MAP_LO, 32'h0211, CDS_RESP_OKAY);
    rd(CDS_REG_MAP_LO, 32'h0201, CDS_RESP_OKAY);
    alarm_active <= 8'h01;
    repeat (3) @(posedge clk_sys);
    chk("relay", 32'h01, 32'(relay_out_q));
    alarm_active <= 8'h04;
    repeat (3) @(posedge clk_sys);
    chk("relay", 32'h00, 32'(relay_out_q));
    relay_option_fitted <= 1'b1;
    wr(CDS_REG_MAP_LO, 32'h0211, CDS_RESP_OKAY);
    rd(CDS_REG_MAP_LO, 32'h0211, CDS_RESP_OKAY);
    alarm_active <= 8'h03;
    repeat (3) @(posedge clk_sys);
    chk("relay", 32'h13, 32'(relay_out_q));
    // Tag needs both the six-digit strap and the enable bit.
    chk("tag", 0, 32'(tag_show_q));
    six_digit_display <= 1'b1;
    repeat (5) @(posedge clk_sys);
    chk("tag", 1, 32'(tag_show_q));
    wr(CDS_REG_CONFIG, 32'h0212, CDS_RESP_OKAY);
    repeat (2) @(posedge clk_sys);
    chk("tag", 0, 32'(tag_show_q));
    rd(CDS_REG_STATUS, held == 4'h1 ? 32'h1c1 : 32'h1c0, CDS_RESP_OKAY);
    conclude();
  end
endmodule // testbench
